// File: design/sbsi_pkg.sv
// Constants, types and helpers of the synchronous burst SRAM interface.
// Assumes nothing of its surroundings; every design file uses it by scope.
package sbsi_pkg;

    // ****************************************************************
    // Array shape
    // ****************************************************************
    localparam int WIDE_ADDR_W = 19;       // 524,288 locations
    localparam int WIDE_LANES = 4;         // 4 lanes of 9 bits: 36 bits
    localparam int NARROW_ADDR_W = 20;     // 1,048,576 locations
    localparam int NARROW_LANES = 2;       // 2 lanes of 9 bits: 18 bits
    localparam int LANE_DATA_W = 8;        // Data bits of one lane
    localparam int BURST_W = 2;            // Burst counter width
    localparam int MAX_LANES = 4;          // Width of the lane helpers

    // ****************************************************************
    // Buffering and reset
    // ****************************************************************
    localparam int WR_FIFO_DEPTH = 32;
    localparam logic [1:0] BEAT_RESET = 2'h0;

    // Operation taken at a clock edge
    typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE} sbsi_op_t;

    // Low address bits of one beat: linear adds, interleaved XORs
    function automatic logic [BURST_W-1:0] burst_lsbs(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] beat,
        input logic interleaved
    );
        burst_lsbs = interleaved ? (start ^ beat) : (start + beat);
    endfunction

    // Lanes to write: all-lane write wins, else gate plus lane selects
    function automatic logic [MAX_LANES-1:0] lane_enables(
        input logic all_lane_n,
        input logic gate_n,
        input logic [MAX_LANES-1:0] select_n
    );
        if (!all_lane_n)
        begin
            lane_enables = 4'hF;
        end
        else if (!gate_n)
        begin
            lane_enables = ~select_n;
        end
        else
        begin
            lane_enables = 4'h0;
        end
    endfunction

endpackage

// File: design/sbsi_fifo.sv
// Write FIFO between the captured write beats and the array.
// Assumes one clock and an already synchronised active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sbsi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = sbsi_pkg::WR_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] store_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;

    // ****************************************************************
    // Handshakes
    // ****************************************************************
    assign in_ready_out = (count_q != DEPTH[PW:0]);
    assign out_valid_out = (count_q != '0);
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;
    assign out_data_out = store_q[rd_ptr_q];

    // Storage is written only on an accepted push
    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            store_q[wr_ptr_q] <= in_data_in;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // Occupancy gives honest full and empty
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            count_q <= '0;
        end
        else if (push && !pop)
        begin
            count_q <= count_q + 1'b1;
        end
        else if (pop && !push)
        begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: design/sbsi_array.sv
// Storage array with one masked write port and one registered read port.
// Assumes one clock; a same-cycle write to the read address is forwarded.
`timescale 1ns/100ps
`default_nettype none
module sbsi_array #(
    parameter int ADDR_W = sbsi_pkg::WIDE_ADDR_W,
    parameter int WIDTH = 36
) (
    // Clock
    input wire logic clk_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [WIDTH-1:0] wr_mask_in,
    // Read port
    input wire logic rd_en_in,
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem_q [2**ADDR_W];
    logic [WIDTH-1:0] old_word;
    logic [WIDTH-1:0] new_word;

    // Merge the masked write into the stored word
    assign old_word = mem_q[wr_addr_in];
    assign new_word = (old_word & ~wr_mask_in) | (wr_data_in & wr_mask_in);

    // Self-timed update: the whole word lands at the edge
    always_ff @(posedge clk_in)
    begin
        if (wr_en_in)
        begin
            mem_q[wr_addr_in] <= new_word;
        end
    end

    // Read register; forwarding keeps a just-drained write visible
    always_ff @(posedge clk_in)
    begin
        if (rd_en_in)
        begin
            if (wr_en_in && (wr_addr_in == rd_addr_in))
            begin
                rd_data_out <= new_word;
            end
            else
            begin
                rd_data_out <= mem_q[rd_addr_in];
            end
        end
    end
endmodule
`default_nettype wire

// File: design/sbsi_top.sv
// Synchronous pipelined burst SRAM, seen from behind its pins.
// Assumes all synchronous pins change away from the rising clock edge;
// the output enable and sleep pins act without the clock.
//
// How it works
// - Address, data and control pins are registered at the rising edge.
// - A write starts at an edge; the array update is self-timed.
// - One write may touch any subset of the lanes, one to all.
// - Byte gate plus lane selects write only the chosen lanes.
// - All-lane write writes every lane, whatever gate and selects say.
// - Either address strobe loads the external address as burst start.
// - Later burst addresses are made inside, stepping only on advance.
// - Burst order select low gives linear order.
// - Burst order select high gives interleaved order.
// - A two-bit burst counter supplies the two low address bits.
// - The counter preloads from the two low address pins at start.
// - Wide variant: 524,288 words of 36 bits.
// - Narrow variant: 1,048,576 words of 18 bits.
// - Deselect through chip selects enters reduced power automatically.
// - Reads leave a pipeline register; outputs release two cycles late.
// - Sleep request holds the device in standby while asserted.
// - All three chip selects must be active for a new access.
// - Data lines are shared; the far side stays off during reads.
// - Processor strobe always starts a read; writes follow next edge.
// - Each lane select writes its data byte and parity bit only.
// - Advance held off suspends the burst on the current address.
// - Output enable and sleep act without clock sampling.
`timescale 1ns/100ps
`default_nettype none
module sbsi_top #(
    parameter int ADDR_W = sbsi_pkg::WIDE_ADDR_W,
    parameter int LANES = sbsi_pkg::WIDE_LANES,
    parameter int FIFO_DEPTH = sbsi_pkg::WR_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Address
    input wire logic [ADDR_W-3:0] addr_upper_in,
    input wire logic [1:0] burst_start_lsbs_in,
    // Chip selects
    input wire logic cs_n_in,
    input wire logic chip_select_aux_in,
    input wire logic chip_select_aux_n_in,
    // Burst control
    input wire logic proc_addr_strobe_n_in,
    input wire logic ctrl_addr_strobe_n_in,
    input wire logic burst_advance_n_in,
    input wire logic burst_order_in,
    // Write control
    input wire logic all_lane_write_n_in,
    input wire logic byte_write_gate_n_in,
    input wire logic [LANES-1:0] lane_write_select_n_in,
    // Unclocked controls
    input wire logic out_enable_n_in,
    input wire logic sleep_request_in,
    // Shared data pins
    input wire logic [LANES*8-1:0] data_io_lanes_in,
    output logic [LANES*8-1:0] data_io_lanes_out,
    output logic data_io_lanes_oe_out,
    input wire logic [LANES-1:0] parity_io_lanes_in,
    output logic [LANES-1:0] parity_io_lanes_out,
    output logic parity_io_lanes_oe_out,
    // Status
    output logic low_power_out,
    output logic write_ready_out
);
    localparam int DW = LANES * sbsi_pkg::LANE_DATA_W;
    localparam int WW = DW + LANES;
    localparam int FW = ADDR_W + WW + WW;
    localparam int BW = sbsi_pkg::BURST_W;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic rst_meta_q;
    logic rst_n_q;
    logic active_q;
    logic active_d;
    logic order_q;
    logic [ADDR_W-3:0] base_q;
    logic [ADDR_W-3:0] base_d;
    logic [BW-1:0] start_q;
    logic [BW-1:0] start_d;
    logic [BW-1:0] beat_q;
    logic [BW-1:0] beat_d;
    sbsi_pkg::sbsi_op_t op_q;
    sbsi_pkg::sbsi_op_t op_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [WW-1:0] wdata_q;
    logic [WW-1:0] wmask_q;
    logic [LANES-1:0] lanes_d;
    logic selected;
    logic proc_start;
    logic ctrl_start;
    logic rd_stage1_q;
    logic rd_stage2_q;
    logic [WW-1:0] dout_q;
    logic [WW-1:0] rd_word;
    logic fifo_valid;
    logic [FW-1:0] fifo_word;
    logic drain_ready;

    // Widen a lane mask into a bit mask over data then parity
    function automatic logic [WW-1:0] lane_mask(
        input logic [LANES-1:0] lanes
    );
        lane_mask = '0;
        for (int i = 0; i < LANES; i++)
        begin
            lane_mask[i*8 +: 8] = {8{lanes[i]}};
            lane_mask[DW + i] = lanes[i];
        end
    endfunction

    // ****************************************************************
    // Reset release
    // ****************************************************************

    // Two flops release the reset cleanly against the clock
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ****************************************************************
    // Cycle decode
    // ****************************************************************

    // All three selects active, and which strobe opens a burst
    always_comb
    begin
        selected = !cs_n_in && chip_select_aux_in && !chip_select_aux_n_in;
        proc_start = !proc_addr_strobe_n_in && !cs_n_in;
        ctrl_start = !ctrl_addr_strobe_n_in && !proc_start;
        lanes_d = LANES'(sbsi_pkg::lane_enables(all_lane_write_n_in,
            byte_write_gate_n_in,
            sbsi_pkg::MAX_LANES'({{sbsi_pkg::MAX_LANES{1'b1}},
                lane_write_select_n_in})));
    end

    // Next burst state and the operation of this edge
    always_comb
    begin
        active_d = active_q;
        base_d = base_q;
        start_d = start_q;
        beat_d = beat_q;
        op_d = sbsi_pkg::OP_NONE;
        addr_d = addr_q;
        if (sleep_request_in)
        begin
            // Standby holds all state and takes nothing
            op_d = sbsi_pkg::OP_NONE;
        end
        else if (proc_start || ctrl_start)
        begin
            if (selected)
            begin
                // Load external address, preload the counter
                active_d = 1'b1;
                base_d = addr_upper_in;
                start_d = burst_start_lsbs_in;
                beat_d = sbsi_pkg::BEAT_RESET;
                addr_d = {addr_upper_in, burst_start_lsbs_in};
                // Processor strobe always reads
                if (proc_start || (lanes_d == '0))
                begin
                    op_d = sbsi_pkg::OP_READ;
                end
                else
                begin
                    op_d = sbsi_pkg::OP_WRITE;
                end
            end
            else
            begin
                // Deselect cycle ends the burst
                active_d = 1'b0;
            end
        end
        else if (active_q)
        begin
            // Step only on advance; otherwise stay
            if (!burst_advance_n_in)
            begin
                beat_d = beat_q + 1'b1;
            end
            // Upper bits never change inside a burst
            addr_d = {base_q, sbsi_pkg::burst_lsbs(start_q, beat_d,
                order_q)};
            op_d = (lanes_d == '0) ? sbsi_pkg::OP_READ
                                   : sbsi_pkg::OP_WRITE;
        end
    end

    // ****************************************************************
    // Input registers
    // ****************************************************************

    // Burst state registers
    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            active_q <= 1'b0;
            base_q <= '0;
            start_q <= sbsi_pkg::BEAT_RESET;
            beat_q <= sbsi_pkg::BEAT_RESET;
        end
        else
        begin
            active_q <= active_d;
            base_q <= base_d;
            start_q <= start_d;
            beat_q <= beat_d;
        end
    end

    // Burst order pin is sampled like every synchronous pin
    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            order_q <= 1'b1;
        end
        else
        begin
            order_q <= burst_order_in;
        end
    end

    // Operation, address, write data and lane mask of this edge
    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            op_q <= sbsi_pkg::OP_NONE;
            addr_q <= '0;
            wdata_q <= '0;
            wmask_q <= '0;
        end
        else
        begin
            op_q <= op_d;
            addr_q <= addr_d;
            wdata_q <= {parity_io_lanes_in, data_io_lanes_in};
            wmask_q <= lane_mask(lanes_d);
        end
    end

    // ****************************************************************
    // Write path
    // ****************************************************************

    // Captured writes queue here; drain pauses in standby
    assign drain_ready = !sleep_request_in;

    sbsi_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n_q),
        .in_valid_in(op_q == sbsi_pkg::OP_WRITE),
        .in_ready_out(write_ready_out),
        .in_data_in({addr_q, wdata_q, wmask_q}),
        .out_valid_out(fifo_valid),
        .out_ready_in(drain_ready),
        .out_data_out(fifo_word)
    );

    // ****************************************************************
    // Array
    // ****************************************************************

    // Depth and width follow the variant parameters
    sbsi_array #(
        .ADDR_W(ADDR_W),
        .WIDTH(WW)
    ) u_array (
        .clk_in(core_clk_in),
        .wr_en_in(fifo_valid && drain_ready),
        .wr_addr_in(fifo_word[FW-1 -: ADDR_W]),
        .wr_data_in(fifo_word[2*WW-1 -: WW]),
        .wr_mask_in(fifo_word[WW-1:0]),
        .rd_en_in(op_q == sbsi_pkg::OP_READ),
        .rd_addr_in(addr_q),
        .rd_data_out(rd_word)
    );

    // ****************************************************************
    // Read pipeline
    // ****************************************************************

    // Read valid walks two stages; each read drives the outputs for one cycle
    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            rd_stage1_q <= 1'b0;
            rd_stage2_q <= 1'b0;
        end
        else
        begin
            rd_stage1_q <= (op_q == sbsi_pkg::OP_READ);
            rd_stage2_q <= rd_stage1_q;
        end
    end

    // Output register loads only fresh read data
    always_ff @(posedge core_clk_in or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            dout_q <= '0;
        end
        else if (rd_stage1_q)
        begin
            dout_q <= rd_word;
        end
    end

    // ****************************************************************
    // Pins and status
    // ****************************************************************

    // Drive only while a read is out, enabled and awake
    assign data_io_lanes_oe_out = rd_stage2_q && !out_enable_n_in
                                  && !sleep_request_in;
    assign parity_io_lanes_oe_out = data_io_lanes_oe_out;
    assign data_io_lanes_out = dout_q[DW-1:0];
    assign parity_io_lanes_out = dout_q[WW-1:DW];

    // Reduced power when deselected or asleep
    assign low_power_out = !active_q || sleep_request_in;

endmodule
`default_nettype wire

// File: tb/sbsi_sva.sv
// Pin-level checker for the burst SRAM top module.
// Assumes it is bound into sbsi_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module sbsi_sva (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Selects, strobes and unclocked controls
    input wire logic cs_n_in,
    input wire logic chip_select_aux_in,
    input wire logic chip_select_aux_n_in,
    input wire logic proc_addr_strobe_n_in,
    input wire logic ctrl_addr_strobe_n_in,
    input wire logic out_enable_n_in,
    input wire logic sleep_request_in,
    // Output enables and status
    input wire logic data_io_lanes_oe_out,
    input wire logic parity_io_lanes_oe_out,
    input wire logic low_power_out,
    input wire logic write_ready_out
);
    // ****************************************************************
    // Access starts and deselects
    // ****************************************************************
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    wire logic sel_all = !cs_n_in && chip_select_aux_in &&
        !chip_select_aux_n_in;
    sequence s_rd_start;
        !sleep_request_in && !proc_addr_strobe_n_in && sel_all;
    endsequence
    sequence s_desel;
        !sleep_request_in && !sel_all &&
        (!ctrl_addr_strobe_n_in || (!proc_addr_strobe_n_in && !cs_n_in));
    endsequence
    property p_oe_cause;
        data_io_lanes_oe_out |-> !out_enable_n_in && !sleep_request_in;
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("oe without cause");
    property p_par_oe;
        parity_io_lanes_oe_out == data_io_lanes_oe_out;
    endproperty
    a_par_oe: assert property (p_par_oe) else $error("lane enables split");
    property p_sleep_lp;
        sleep_request_in [*2] |-> low_power_out && !parity_io_lanes_oe_out;
    endproperty
    a_sleep_lp: assert property (p_sleep_lp) else $error("sleep not held");
    property p_read_out;
        s_rd_start ##1 !sleep_request_in [*2] ##1
        (!out_enable_n_in && !sleep_request_in) |-> data_io_lanes_oe_out;
    endproperty
    a_read_out: assert property (p_read_out) else $error("read not driven");
    property p_read_awake;
        s_rd_start ##1 !sleep_request_in |-> !low_power_out;
    endproperty
    a_read_awake: assert property (p_read_awake) else $error("asleep in burst");
    property p_desel_lp;
        s_desel |=> low_power_out;
    endproperty
    a_desel_lp: assert property (p_desel_lp) else $error("no power down");
    property p_desel_release;
        s_desel |-> ##3 !data_io_lanes_oe_out;
    endproperty
    a_desel_release: assert property (p_desel_release) else $error("late release");
    property p_write_room;
        !sleep_request_in |-> write_ready_out;
    endproperty
    a_write_room: assert property (p_write_room) else $error("write fifo full");
endmodule
bind sbsi_top sbsi_sva u_sva (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .cs_n_in(cs_n_in),
    .chip_select_aux_in(chip_select_aux_in),
    .chip_select_aux_n_in(chip_select_aux_n_in),
    .proc_addr_strobe_n_in(proc_addr_strobe_n_in),
    .ctrl_addr_strobe_n_in(ctrl_addr_strobe_n_in),
    .out_enable_n_in(out_enable_n_in),
    .sleep_request_in(sleep_request_in),
    .data_io_lanes_oe_out(data_io_lanes_oe_out),
    .parity_io_lanes_oe_out(parity_io_lanes_oe_out),
    .low_power_out(low_power_out), .write_ready_out(write_ready_out));
`default_nettype wire

// File: tb/sbsi_ctrl_model.sv
// Cache controller model that drives the SRAM pins one cycle at a time.
// Assumes the caller enters beat just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module sbsi_ctrl_model (
    // Clock
    input wire logic clk_in,
    // Device side of the shared lines
    input wire logic [35:0] dev_word_in,
    input wire logic dev_oe_in,
    // Controls, address and lane selects
    output logic [7:0] ctl_out,
    output logic [5:0] addr_out,
    output logic [3:0] sel_n_out,
    // Level seen on the shared lines
    output logic [35:0] wire_out
);
    logic drv_q = 1'b0;
    logic [35:0] wd_q = 36'h0;
    // Idle pins: selected, no strobes
    initial
    begin
        ctl_out = 8'h5F;
        addr_out = 6'h00;
        sel_n_out = 4'hF;
    end
    // Released lines show the inverse of the last word
    assign wire_out = dev_oe_in ? dev_word_in : drv_q ? wd_q : ~wd_q;
    // One cycle of pins, held up to the sampling edge
    task automatic beat(input logic [7:0] c, input logic [5:0] a,
        input logic [3:0] s, input logic d, input logic [35:0] w);
        ctl_out = c;
        addr_out = a;
        sel_n_out = s;
        drv_q = d && !dev_oe_in;
        wd_q = w;
        @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// File: tb/sbsi_top_test.sv
// Self-checking bench for the burst SRAM, using the controller model.
// Assumes a reduced array of 64 words and a write FIFO of four.
`timescale 1ns/100ps
`default_nettype none
module sbsi_top_test;
    localparam logic [7:0] IDLE = 8'h5F;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic order = 1'b1;
    logic oen = 1'b1;
    logic sleep = 1'b0;
    logic [7:0] ctl;
    logic [5:0] addr;
    logic [3:0] sel_n;
    logic [35:0] wire_w;
    logic [31:0] dq_out;
    logic [3:0] par_out;
    logic dq_oe, par_oe, low_pw, wr_rdy;
    logic [35:0] mem [64];
    logic cur_rd = 1'b0;
    logic [35:0] cur_exp, e0, e1, e2;
    logic [2:0] sh = 3'h0;
    logic [1:0] st, bt;
    logic [3:0] sels [3] = '{4'hE, 4'h5, 4'h0};
    logic [7:0] desel [3] = '{8'h17, 8'hD7, 8'h77};
    int n_mismatch = 0;
    int checks_done = 0;
    // ****************************************************************
    // Device, controller and clock
    // ****************************************************************
    sbsi_top #(.ADDR_W(6), .LANES(4), .FIFO_DEPTH(4)) dut (
        .core_clk_in(clk), .nrst_in(nrst), .addr_upper_in(addr[5:2]),
        .burst_start_lsbs_in(addr[1:0]), .cs_n_in(ctl[7]),
        .chip_select_aux_in(ctl[6]), .chip_select_aux_n_in(ctl[5]),
        .proc_addr_strobe_n_in(ctl[4]), .ctrl_addr_strobe_n_in(ctl[3]),
        .burst_advance_n_in(ctl[2]), .burst_order_in(order),
        .all_lane_write_n_in(ctl[1]), .byte_write_gate_n_in(ctl[0]),
        .lane_write_select_n_in(sel_n), .out_enable_n_in(oen),
        .sleep_request_in(sleep), .data_io_lanes_in(wire_w[31:0]),
        .data_io_lanes_out(dq_out), .data_io_lanes_oe_out(dq_oe),
        .parity_io_lanes_in(wire_w[35:32]), .parity_io_lanes_out(par_out),
        .parity_io_lanes_oe_out(par_oe), .low_power_out(low_pw),
        .write_ready_out(wr_rdy));
    sbsi_ctrl_model u_ctl (.clk_in(clk), .dev_word_in({par_out, dq_out}),
        .dev_oe_in(dq_oe), .ctl_out(ctl), .addr_out(addr),
        .sel_n_out(sel_n), .wire_out(wire_w));
    always #5 clk = ~clk;
    task automatic stop_test();
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [36:0] got, input logic [36:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // One pin cycle; a read keeps the device's output enabled
    task automatic go(input logic [7:0] c, input logic [5:0] a,
        input logic [3:0] s, input logic d, input logic [35:0] w,
        input logic r);
        @(negedge clk);
        cur_rd = r;
        cur_exp = mem[a];
        if (r)
            oen = 1'b0;
        if (d)
            oen = 1'b1;
        u_ctl.beat(c, a, s, d, w);
    endtask
    task automatic idle(input int n);
        repeat (n) go(IDLE, 6'h00, 4'hF, 1'b0, 36'h0, 1'b0);
    endtask
    // Write with all-lane (g low) or gated lane selects
    task automatic wr(input logic [5:0] a, input logic g,
        input logic [3:0] s, input logic [35:0] w);
        for (int i = 0; i < 4; i++)
            if (!g || !s[i])
            begin
                mem[a][8*i+:8] = w[8*i+:8];
                mem[a][32+i] = w[32+i];
            end
        go(g ? 8'h56 : 8'h54, a, s, 1'b1, w, 1'b0);
    endtask
    // Reads show two edges later
    always @(posedge clk)
    begin
        sh <= {sh[1:0], cur_rd};
        e0 <= cur_exp;
        e1 <= e0;
        e2 <= e1;
    end
    always @(negedge clk)
    begin
        #2;
        if (sh[2])
            check({dq_oe, wire_w}, {1'b1, e2});
    end
    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        idle(3);
        for (int i = 0; i < 4; i++)
            wr({4'hC, 2'(i)}, 1'b0, 4'hA, 36'h9_1234_5670 + 36'(i));
        for (int i = 0; i < 3; i++)
            wr({4'hC, 2'(i)}, 1'b1, sels[i], 36'hF_FFFF_FFFF);
        check(37'(wr_rdy), 37'h1);
        for (int i = 0; i < 4; i++)
            go(8'h57, {4'hC, 2'(i)}, 4'hF, 1'b0, 36'h0, 1'b1);
        go(8'h4C, 6'h31, 4'h0, 1'b0, 36'h0, 1'b1);
        go(8'h57, 6'h31, 4'hF, 1'b0, 36'h0, 1'b1);
        idle(3);
        for (int o = 0; o < 2; o++)
        begin
            @(negedge clk);
            order = o[0];
            idle(2);
            st = o[0] ? 2'h1 : 2'h2;
            bt = 2'h0;
            go(o[0] ? 8'h4F : 8'h57, {4'hC, st}, 4'hF, 1'b0, 36'h0, 1'b1);
            for (int k = 1; k < 7; k++)
            begin
                if (k != 3)
                    bt = bt + 2'h1;
                go(k != 3 ? 8'h5B : IDLE, {4'hC, o[0] ? st ^ bt : st + bt},
                    4'hF, 1'b0, 36'h0, 1'b1);
            end
            idle(3);
        end
        for (int i = 0; i < 3; i++)
        begin
            go(8'h4F, 6'h32, 4'hF, 1'b0, 36'h0, 1'b1);
            go(desel[i], 6'h00, 4'hF, 1'b0, 36'h0, 1'b0);
            #2;
            check(37'(low_pw), 37'h1);
            idle(2);
            #2;
            check(37'(dq_oe), 37'h0);
        end
        go(8'h4F, 6'h30, 4'hF, 1'b0, 36'h0, 1'b1);
        idle(3);
        @(negedge clk);
        sleep = 1'b1;
        #2;
        check(37'({low_pw, dq_oe, par_oe}), 37'h4);
        repeat (3) @(negedge clk);
        check(37'({low_pw, dq_oe, par_oe}), 37'h4);
        sleep = 1'b0;
        idle(3);
        #2;
        check({dq_oe, wire_w}, {1'b1, mem[6'h30]});
        @(negedge clk);
        oen = 1'b1;
        #2;
        check(37'(dq_oe), 37'h0);
        stop_test();
    end
endmodule
`default_nettype wire
